// [hw/periph_reset_pkg.sv]
// constants and types for the peripheral soft reset control registers
// assumes a plain register port on the system control block, 40 MHz ref_clk
// Overview of operation
// - register a at 0x044, 32 bits, resets to all zero
// - register b at 0x048, 32 bits, resets to all zero
// - writes to register a masked by capability word two
// - writes to register b masked by capability word four
// - bit 24 of a resets comparator zero
// - bits 19..16 of a reset counters 3..0
// - bit 12 of a resets two-wire unit zero
// - bits 5 and 4 of a reset sync serial units 1 and 0
// - bits 2..0 of a reset async serial units 2..0
// - bits 7..0 of b reset io ports h..a
// - unassigned bits read zero and ignore writes
package periph_reset_pkg;

  localparam logic [11:0] CTRL_A_OFFSET = 12'h044;
  localparam logic [11:0] CTRL_B_OFFSET = 12'h048;
  localparam logic [31:0] CTRL_A_RESET = 32'h00000000;
  localparam logic [31:0] CTRL_B_RESET = 32'h00000000;
  localparam logic [31:0] CTRL_A_IMPL = 32'h010F1037;
  localparam logic [31:0] CTRL_B_IMPL = 32'h000000FF;

  localparam int COMPARATOR_BIT = 24;
  localparam int COUNTER_LSB = 16;
  localparam int TWO_WIRE_BIT = 12;
  localparam int SYNC_SERIAL_LSB = 4;
  localparam int ASYNC_SERIAL_LSB = 0;
  localparam int IO_PORT_LSB = 0;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef struct packed {
    logic comparator_zero_reset;
    logic [3:0] gp_counter_reset;
    logic two_wire_unit0_reset;
    logic [1:0] sync_serial_reset;
    logic [2:0] async_serial_reset;
    logic [7:0] io_port_reset;
  } periph_resets_s;

endpackage

// [hw/peripheral_soft_reset_regs.sv]
// peripheral soft reset control registers a and b with capability masking
// assumes a single-cycle master that never issues read and write together
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps

module peripheral_soft_reset_regs (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire periph_reset_pkg::reg_req_s req,
  input wire logic [31:0] capability_word_two,
  input wire logic [31:0] capability_word_four,
  output logic [31:0] rdata,
  output periph_reset_pkg::periph_resets_s resets
);

  logic [31:0] ctrl_a_q;
  logic [31:0] ctrl_b_q;
  logic [31:0] rdata_d;
  logic comparator_q;
  logic [3:0] counter_q;
  logic two_wire_q;
  logic [1:0] sync_serial_q;
  logic [2:0] async_serial_q;
  logic [7:0] io_port_q;

  ////////////////////////////////////////////////////////////////////////////
  // masked write merge: bits not present or unassigned keep zero
  function automatic logic [31:0] masked_write(
    input logic [31:0] wdata,
    input logic [31:0] impl,
    input logic [31:0] cap
  );
    masked_write = wdata & impl & cap;
  endfunction

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_a_q <= periph_reset_pkg::CTRL_A_RESET;
    end
    else if (req.wr && req.addr == periph_reset_pkg::CTRL_A_OFFSET)
    begin
      ctrl_a_q <= masked_write(req.wdata, periph_reset_pkg::CTRL_A_IMPL, capability_word_two);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_b_q <= periph_reset_pkg::CTRL_B_RESET;
    end
    else if (req.wr && req.addr == periph_reset_pkg::CTRL_B_OFFSET)
    begin
      ctrl_b_q <= masked_write(req.wdata, periph_reset_pkg::CTRL_B_IMPL, capability_word_four);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port, data one cycle after the strobe, zero otherwise
  always_comb
  begin
    rdata_d = 32'h00000000;
    if (req.rd)
    begin
      unique case (req.addr)
        periph_reset_pkg::CTRL_A_OFFSET: rdata_d = ctrl_a_q;
        periph_reset_pkg::CTRL_B_OFFSET: rdata_d = ctrl_b_q;
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdata <= 32'h00000000;
    end
    else
    begin
      rdata <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset lines mirror the register bits through a flop stage
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      comparator_q <= 1'b0;
    end
    else
    begin
      comparator_q <= ctrl_a_q[periph_reset_pkg::COMPARATOR_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      counter_q <= 4'h0;
    end
    else
    begin
      counter_q <= ctrl_a_q[periph_reset_pkg::COUNTER_LSB +: 4];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      two_wire_q <= 1'b0;
    end
    else
    begin
      two_wire_q <= ctrl_a_q[periph_reset_pkg::TWO_WIRE_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync_serial_q <= 2'h0;
    end
    else
    begin
      sync_serial_q <= ctrl_a_q[periph_reset_pkg::SYNC_SERIAL_LSB +: 2];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      async_serial_q <= 3'h0;
    end
    else
    begin
      async_serial_q <= ctrl_a_q[periph_reset_pkg::ASYNC_SERIAL_LSB +: 3];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      io_port_q <= 8'h00;
    end
    else
    begin
      io_port_q <= ctrl_b_q[periph_reset_pkg::IO_PORT_LSB +: 8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output struct is plain wiring of the line flops
  assign resets = {comparator_q, counter_q, two_wire_q, sync_serial_q, async_serial_q, io_port_q};

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_write_a_masked: assert property (@(posedge ref_clk) disable iff (!reset_n)
    req.wr && req.addr == periph_reset_pkg::CTRL_A_OFFSET
    |=> ctrl_a_q == ($past(req.wdata) & $past(capability_word_two) & periph_reset_pkg::CTRL_A_IMPL))
    else $error("register a write not masked correctly");

  a_write_b_masked: assert property (@(posedge ref_clk) disable iff (!reset_n)
    req.wr && req.addr == periph_reset_pkg::CTRL_B_OFFSET
    |=> ctrl_b_q == ($past(req.wdata) & $past(capability_word_four) & periph_reset_pkg::CTRL_B_IMPL))
    else $error("register b write not masked correctly");

  a_a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (ctrl_a_q & ~periph_reset_pkg::CTRL_A_IMPL) == 32'h00000000)
    else $error("register a reserved bit set");

  a_b_reserved_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ctrl_b_q[31:8] == 24'h000000)
    else $error("register b reserved bit set");

  a_read_a_data: assert property (@(posedge ref_clk) disable iff (!reset_n)
    req.rd && req.addr == periph_reset_pkg::CTRL_A_OFFSET && !req.wr |=> rdata == $past(ctrl_a_q))
    else $error("register a read data wrong");

  a_read_b_data: assert property (@(posedge ref_clk) disable iff (!reset_n)
    req.rd && req.addr == periph_reset_pkg::CTRL_B_OFFSET && !req.wr |=> rdata == $past(ctrl_b_q))
    else $error("register b read data wrong");

  a_comparator_line: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ##1 resets.comparator_zero_reset == $past(ctrl_a_q[24]))
    else $error("comparator reset line mismatch");

  a_counter_lines: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ##1 resets.gp_counter_reset == $past(ctrl_a_q[19:16]))
    else $error("counter reset lines mismatch");

  a_two_wire_line: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ##1 resets.two_wire_unit0_reset == $past(ctrl_a_q[12]))
    else $error("two-wire reset line mismatch");

  a_serial_lines: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ##1 {resets.sync_serial_reset, resets.async_serial_reset} == $past({ctrl_a_q[5:4], ctrl_a_q[2:0]}))
    else $error("serial reset lines mismatch");

  a_async_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    req.wr && req.addr == periph_reset_pkg::CTRL_A_OFFSET && req.wdata[0] && capability_word_two[0]
    |=> ##1 resets.async_serial_reset[0])
    else $error("async serial 0 not held in reset");

  a_port_lines: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ##1 resets.io_port_reset == $past(ctrl_b_q[7:0]))
    else $error("io port reset lines mismatch");

  a_release_after_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
    req.wr && req.addr == periph_reset_pkg::CTRL_B_OFFSET && !req.wdata[7]
    |=> ##1 !resets.io_port_reset[7])
    else $error("io port h not released");

  a_rdata_idle_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !req.rd |=> rdata == 32'h00000000)
    else $error("read data not zero when idle");

  a_unmapped_read_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
    req.rd && req.addr != periph_reset_pkg::CTRL_A_OFFSET && req.addr != periph_reset_pkg::CTRL_B_OFFSET
    |=> rdata == 32'h00000000)
    else $error("unmapped read not zero");

  a_a_hold_idle: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !(req.wr && req.addr == periph_reset_pkg::CTRL_A_OFFSET) |=> $stable(ctrl_a_q))
    else $error("register a changed without write");

  a_b_hold_idle: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !(req.wr && req.addr == periph_reset_pkg::CTRL_B_OFFSET) |=> $stable(ctrl_b_q))
    else $error("register b changed without write");

  a_a_write_keeps_b: assert property (@(posedge ref_clk) disable iff (!reset_n)
    req.wr && req.addr == periph_reset_pkg::CTRL_A_OFFSET |=> $stable(ctrl_b_q))
    else $error("register b changed by write to a");

  a_b_write_keeps_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    req.wr && req.addr == periph_reset_pkg::CTRL_B_OFFSET |=> $stable(ctrl_a_q))
    else $error("register a changed by write to b");

  a_counter_masked: assert property (@(posedge ref_clk) disable iff (!reset_n)
    req.wr && req.addr == periph_reset_pkg::CTRL_A_OFFSET && !capability_word_two[16] |=> !ctrl_a_q[16])
    else $error("absent counter bit was set");

  a_two_wire_masked: assert property (@(posedge ref_clk) disable iff (!reset_n)
    req.wr && req.addr == periph_reset_pkg::CTRL_A_OFFSET && !capability_word_two[12] |=> !ctrl_a_q[12])
    else $error("absent two-wire bit was set");

  a_comparator_masked: assert property (@(posedge ref_clk) disable iff (!reset_n)
    req.wr && req.addr == periph_reset_pkg::CTRL_A_OFFSET && !capability_word_two[24] |=> !ctrl_a_q[24])
    else $error("absent comparator bit was set");

  a_port_a_masked: assert property (@(posedge ref_clk) disable iff (!reset_n)
    req.wr && req.addr == periph_reset_pkg::CTRL_B_OFFSET && !capability_word_four[0] |=> !ctrl_b_q[0])
    else $error("absent port a bit was set");

  a_port_h_masked: assert property (@(posedge ref_clk) disable iff (!reset_n)
    req.wr && req.addr == periph_reset_pkg::CTRL_B_OFFSET && !capability_word_four[7] |=> !ctrl_b_q[7])
    else $error("absent port h bit was set");

  a_comparator_set: assert property (@(posedge ref_clk) disable iff (!reset_n)
    req.wr && req.addr == periph_reset_pkg::CTRL_A_OFFSET && req.wdata[24] && capability_word_two[24]
    |=> ##1 resets.comparator_zero_reset)
    else $error("comparator not held in reset");

  a_counter_set: assert property (@(posedge ref_clk) disable iff (!reset_n)
    req.wr && req.addr == periph_reset_pkg::CTRL_A_OFFSET
    |=> ##1 resets.gp_counter_reset == $past(req.wdata[19:16] & capability_word_two[19:16], 2))
    else $error("counter lines do not follow write");

  a_two_wire_set: assert property (@(posedge ref_clk) disable iff (!reset_n)
    req.wr && req.addr == periph_reset_pkg::CTRL_A_OFFSET && req.wdata[12] && capability_word_two[12]
    |=> ##1 resets.two_wire_unit0_reset)
    else $error("two-wire unit not held in reset");

  a_sync_serial_set: assert property (@(posedge ref_clk) disable iff (!reset_n)
    req.wr && req.addr == periph_reset_pkg::CTRL_A_OFFSET
    |=> ##1 resets.sync_serial_reset == $past(req.wdata[5:4] & capability_word_two[5:4], 2))
    else $error("sync serial lines do not follow write");

  a_async_set: assert property (@(posedge ref_clk) disable iff (!reset_n)
    req.wr && req.addr == periph_reset_pkg::CTRL_A_OFFSET
    |=> ##1 resets.async_serial_reset == $past(req.wdata[2:0] & capability_word_two[2:0], 2))
    else $error("async serial lines do not follow write");

  a_port_set: assert property (@(posedge ref_clk) disable iff (!reset_n)
    req.wr && req.addr == periph_reset_pkg::CTRL_B_OFFSET
    |=> ##1 resets.io_port_reset == $past(req.wdata[7:0] & capability_word_four[7:0], 2))
    else $error("io port lines do not follow write");

  a_comparator_release: assert property (@(posedge ref_clk) disable iff (!reset_n)
    req.wr && req.addr == periph_reset_pkg::CTRL_A_OFFSET && !req.wdata[24]
    |=> ##1 !resets.comparator_zero_reset)
    else $error("comparator not released");

  a_counter_release: assert property (@(posedge ref_clk) disable iff (!reset_n)
    req.wr && req.addr == periph_reset_pkg::CTRL_A_OFFSET && !req.wdata[16]
    |=> ##1 !resets.gp_counter_reset[0])
    else $error("counter 0 not released");

  a_two_wire_release: assert property (@(posedge ref_clk) disable iff (!reset_n)
    req.wr && req.addr == periph_reset_pkg::CTRL_A_OFFSET && !req.wdata[12]
    |=> ##1 !resets.two_wire_unit0_reset)
    else $error("two-wire unit not released");

  a_sync_release: assert property (@(posedge ref_clk) disable iff (!reset_n)
    req.wr && req.addr == periph_reset_pkg::CTRL_A_OFFSET && !req.wdata[4]
    |=> ##1 !resets.sync_serial_reset[0])
    else $error("sync serial 0 not released");

  a_async_release: assert property (@(posedge ref_clk) disable iff (!reset_n)
    req.wr && req.addr == periph_reset_pkg::CTRL_A_OFFSET && !req.wdata[0]
    |=> ##1 !resets.async_serial_reset[0])
    else $error("async serial 0 not released");

  a_port_a_release: assert property (@(posedge ref_clk) disable iff (!reset_n)
    req.wr && req.addr == periph_reset_pkg::CTRL_B_OFFSET && !req.wdata[0]
    |=> ##1 !resets.io_port_reset[0])
    else $error("io port a not released");

endmodule

// [sim/peripheral_soft_reset_regs_bench.sv]
// self-checking bench for the peripheral soft reset control registers
// assumes the design package is compiled first; the bench drives every port itself
`timescale 1ns/1ps

module peripheral_soft_reset_regs_bench;
  logic ref_clk;
  logic reset_n;
  periph_reset_pkg::reg_req_s req;
  logic [31:0] capability_word_two;
  logic [31:0] capability_word_four;
  logic [31:0] rdata;
  periph_reset_pkg::periph_resets_s resets;
  int mismatches;
  int n_tests;

  peripheral_soft_reset_regs uut (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .req(req),
    .capability_word_two(capability_word_two),
    .capability_word_four(capability_word_four),
    .rdata(rdata),
    .resets(resets)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic write_reg(input logic [11:0] addr, input logic [31:0] data);
    @(posedge ref_clk);
    req.addr <= addr;
    req.wdata <= data;
    req.wr <= 1'b1;
    @(posedge ref_clk);
    req.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, then fall to zero
  task automatic read_reg(input logic [11:0] addr, input logic [31:0] exp);
    @(posedge ref_clk);
    req.addr <= addr;
    req.rd <= 1'b1;
    @(posedge ref_clk);
    req.rd <= 1'b0;
    #1;
    check("rdata", exp, rdata);
    @(posedge ref_clk);
    #1;
    check("rdata idle", 32'h00000000, rdata);
  endtask

  // write with given capability words, then check reset lines and both registers
  task automatic step(input logic [11:0] addr, input logic [31:0] data, input logic [31:0] cap2,
    input logic [31:0] cap4, input logic [31:0] exp_a, input logic [31:0] exp_b);
    logic [31:0] line_exp;
    @(posedge ref_clk);
    capability_word_two <= cap2;
    capability_word_four <= cap4;
    write_reg(addr, data);
    line_exp = {13'h0000, exp_a[24], exp_a[19:16], exp_a[12], exp_a[5:4], exp_a[2:0], exp_b[7:0]};
    @(posedge ref_clk);
    #1;
    check("resets", line_exp, {13'h0000, resets});
    read_reg(periph_reset_pkg::CTRL_A_OFFSET, exp_a);
    read_reg(periph_reset_pkg::CTRL_B_OFFSET, exp_b);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    mismatches = 0;
    n_tests = 0;
    reset_n = 1'b0;
    req = '0;
    capability_word_two = 32'hFFFFFFFF;
    capability_word_four = 32'hFFFFFFFF;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    read_reg(12'h044, 32'h00000000);
    read_reg(12'h048, 32'h00000000);
    step(12'h044, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h010F1037, 32'h00000000);
    step(12'h044, 32'hFFFFFFFF, 32'h01000005, 32'hFFFFFFFF, 32'h01000005, 32'h00000000);
    step(12'h044, 32'h01010030, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h01010030, 32'h00000000);
    step(12'h048, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h000000A5, 32'h01010030, 32'h000000A5);
    step(12'h048, 32'hFFFFFF5A, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h01010030, 32'h0000005A);
    // unmapped offsets ignore writes and read zero
    step(12'h04C, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h01010030, 32'h0000005A);
    read_reg(12'h040, 32'h00000000);
    step(12'h044, 32'h00000000, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h00000000, 32'h0000005A);
    // second reset in mid-run clears the stored port bits
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    #1;
    check("resets after reset", 32'h00000000, {13'h0000, resets});
    read_reg(12'h048, 32'h00000000);
    conclude();
  end
endmodule
